// ### design/clock_gate_pkg.sv
// package for the sleep-mode clock gating block: offsets, fields, states
// assumes a plain register port with word byte addresses
package clock_gate_pkg;

  localparam logic [11:0] run_clock_gate_1_offset        = 12'h104;
  localparam logic [11:0] sleep_clock_gate_1_offset      = 12'h114;
  localparam logic [11:0] deep_sleep_clock_gate_1_offset = 12'h124;
  localparam logic [11:0] run_clock_config_offset        = 12'h060;
  localparam logic [11:0] irq_status_offset              = 12'h200;
  localparam logic [11:0] irq_mask_offset                = 12'h204;

  localparam int          comparator_zero_gate_bit = 24;
  localparam int          second_counter_gate_bit  = 17;
  localparam int          first_counter_gate_bit   = 16;
  localparam int          auto_clock_gating_bit    = 27;
  localparam int          unit_count               = 3;

  localparam logic [31:0] gate_mask        = 32'h0103_0000;
  localparam logic [31:0] gate_reset       = 32'h0000_0000;
  localparam logic [31:0] config_reset     = 32'h0000_0000;
  localparam logic [31:0] config_mask      = 32'h0800_0000;
  localparam logic [1:0]  irq_reset        = 2'h0;

  localparam int          fault_event_bit  = 0;
  localparam int          change_event_bit = 1;

  typedef enum logic [1:0] {
    state_run,
    state_sleep,
    state_deep_sleep
  } power_state_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } reg_req_type;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [unit_count-1:0] unit_sel;
  } unit_access_type;

endpackage : clock_gate_pkg

// ### design/unit_enable_select.sv
// picks the gating word for the current power state
// assumes all inputs are from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module unit_enable_select (
  // gating words
  input  wire logic [31:0]                    run_gate_i,
  input  wire logic [31:0]                    sleep_gate_i,
  input  wire logic [31:0]                    deep_gate_i,
  // state
  input  wire clock_gate_pkg::power_state_type state_i,
  input  wire logic                           auto_gating_i,
  // result
  output logic      [31:0]                    gate_o
);
  // without auto gating the run word applies in every state
  wire logic use_sleep = auto_gating_i && (state_i == clock_gate_pkg::state_sleep);
  wire logic use_deep  = auto_gating_i && (state_i == clock_gate_pkg::state_deep_sleep);

  assign gate_o = use_deep  ? deep_gate_i :
                  use_sleep ? sleep_gate_i : run_gate_i;
endmodule : unit_enable_select
`default_nettype wire

// ### design/unit_fault_check.sv
// flags bus accesses to units whose clock is off
// assumes one-cycle access requests on the system clock
`timescale 1ns/1ns
`default_nettype none
module unit_fault_check (
  // access and enables
  input  wire clock_gate_pkg::unit_access_type access_i,
  input  wire logic [clock_gate_pkg::unit_count-1:0] enable_i,
  // result
  output logic                                 fault_o,
  output logic                                 grant_o
);
  wire logic hit_off = |(access_i.unit_sel & ~enable_i);

  assign fault_o = access_i.valid && hit_off;
  assign grant_o = access_i.valid && !hit_off;
endmodule : unit_fault_check
`default_nettype wire

// ### design/sleep_mode_clock_gating.sv
// top of the peripheral clock gating control: registers, selection, faults
// assumes a same-clock register port and same-clock unit access requests
//
// Behaviour
// - each implemented bit enables one unit clock
// - access to unclocked unit answers bus fault
// - sleep gating register resets to zero
// - with auto gating, state picks run, sleep or deep word
// - sleep word used only with auto gating
// - sleep gating register at offset 0x114
// - bits without unit have no effect
`timescale 1ns/1ns
`default_nettype none
module sleep_mode_clock_gating (
  // clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  reset_n_i,
  // register port
  input  wire logic [11:0]                           reg_addr_i,
  input  wire logic [31:0]                           reg_wdata_i,
  input  wire logic                                  reg_write_i,
  input  wire logic                                  reg_read_i,
  output logic      [31:0]                           reg_rdata_o,
  // power state
  input  wire clock_gate_pkg::power_state_type       power_state_i,
  // unit accesses
  input  wire logic                                  unit_access_valid_i,
  input  wire logic                                  unit_access_write_i,
  input  wire logic [clock_gate_pkg::unit_count-1:0] unit_access_sel_i,
  output logic                                       unit_fault_o,
  output logic                                       unit_grant_o,
  // unit clock enables
  output logic      [clock_gate_pkg::unit_count-1:0] unit_clock_en_o,
  // interrupt
  output logic                                       irq_o
);
  clock_gate_pkg::reg_req_type     req;
  clock_gate_pkg::unit_access_type access;

  logic [31:0] run_clock_gate_1;
  logic [31:0] sleep_clock_gate_1;
  logic [31:0] deep_sleep_clock_gate_1;
  logic [31:0] run_clock_config;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [31:0] next_rdata;
  logic [1:0]  next_irq_status;
  logic [clock_gate_pkg::unit_count-1:0] next_unit_en;

  wire logic [31:0] active_gate;
  wire logic        fault;

  assign req.addr  = reg_addr_i;
  assign req.wdata = reg_wdata_i;
  assign req.write = reg_write_i;
  assign req.read  = reg_read_i;

  assign access.valid    = unit_access_valid_i;
  assign access.write    = unit_access_write_i;
  assign access.unit_sel = unit_access_sel_i;

  // address decode
  wire logic hit_run   = req.addr == clock_gate_pkg::run_clock_gate_1_offset;
  wire logic hit_sleep = req.addr == clock_gate_pkg::sleep_clock_gate_1_offset;
  wire logic hit_deep  = req.addr == clock_gate_pkg::deep_sleep_clock_gate_1_offset;
  wire logic hit_cfg   = req.addr == clock_gate_pkg::run_clock_config_offset;
  wire logic hit_stat  = req.addr == clock_gate_pkg::irq_status_offset;
  wire logic hit_mask  = req.addr == clock_gate_pkg::irq_mask_offset;

  // unimplemented positions are never stored, so they read zero
  wire logic [31:0] gated_wdata = req.wdata & clock_gate_pkg::gate_mask;

  wire logic auto_gating = run_clock_config[clock_gate_pkg::auto_clock_gating_bit];

  unit_enable_select u_select (
    .run_gate_i    (run_clock_gate_1),
    .sleep_gate_i  (sleep_clock_gate_1),
    .deep_gate_i   (deep_sleep_clock_gate_1),
    .state_i       (power_state_i),
    .auto_gating_i (auto_gating),
    .gate_o        (active_gate)
  );

  unit_fault_check u_fault (
    .access_i (access),
    .enable_i (unit_clock_en_o),
    .fault_o  (fault),
    .grant_o  (unit_grant_o)
  );

  assign unit_fault_o = fault;

  // unit order: 0 first counter, 1 second counter, 2 comparator
  always_comb begin
    next_unit_en    = '0;
    next_unit_en[0] = active_gate[clock_gate_pkg::first_counter_gate_bit];
    next_unit_en[1] = active_gate[clock_gate_pkg::second_counter_gate_bit];
    next_unit_en[2] = active_gate[clock_gate_pkg::comparator_zero_gate_bit];
  end

  wire logic enables_change = next_unit_en != unit_clock_en_o;

  // set wins over the write-one clear
  always_comb begin
    next_irq_status = irq_status;
    if (req.write && hit_stat) begin
      next_irq_status = irq_status & ~req.wdata[1:0];
    end
    if (fault) begin
      next_irq_status[clock_gate_pkg::fault_event_bit] = 1'b1;
    end
    if (enables_change) begin
      next_irq_status[clock_gate_pkg::change_event_bit] = 1'b1;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_run) begin
      next_rdata = run_clock_gate_1;
    end else if (hit_sleep) begin
      next_rdata = sleep_clock_gate_1;
    end else if (hit_deep) begin
      next_rdata = deep_sleep_clock_gate_1;
    end else if (hit_cfg) begin
      next_rdata = run_clock_config;
    end else if (hit_stat) begin
      next_rdata = {30'h0, irq_status};
    end else if (hit_mask) begin
      next_rdata = {30'h0, irq_mask};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_clock_gate_1        <= clock_gate_pkg::gate_reset;
      sleep_clock_gate_1      <= clock_gate_pkg::gate_reset;
      deep_sleep_clock_gate_1 <= clock_gate_pkg::gate_reset;
      run_clock_config        <= clock_gate_pkg::config_reset;
      irq_mask                <= clock_gate_pkg::irq_reset;
    end else if (req.write) begin
      if (hit_run) begin
        run_clock_gate_1 <= gated_wdata;
      end
      if (hit_sleep) begin
        sleep_clock_gate_1 <= gated_wdata;
      end
      if (hit_deep) begin
        deep_sleep_clock_gate_1 <= gated_wdata;
      end
      if (hit_cfg) begin
        run_clock_config <= req.wdata & clock_gate_pkg::config_mask;
      end
      if (hit_mask) begin
        irq_mask <= req.wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status      <= clock_gate_pkg::irq_reset;
      reg_rdata_o     <= 32'h0000_0000;
      unit_clock_en_o <= '0;
    end else begin
      irq_status      <= next_irq_status;
      unit_clock_en_o <= next_unit_en;
      if (req.read) begin
        reg_rdata_o <= next_rdata;
      end else begin
        reg_rdata_o <= 32'h0000_0000;
      end
    end
  end

  assign irq_o = |(irq_status & irq_mask);
endmodule : sleep_mode_clock_gating
`default_nettype wire

// ### test/sleep_mode_clock_gating_properties.sv
// checker for the clock gating top: unit answers, read port, enables
// assumes it is bound onto the top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module sleep_mode_clock_gating_properties (
  input wire logic                            clk_i, reset_n_i, reg_write_i, reg_read_i,
  input wire logic [11:0]                     reg_addr_i,
  input wire logic [31:0]                     reg_wdata_i, reg_rdata_o,
  input wire clock_gate_pkg::power_state_type power_state_i,
  input wire logic                            unit_access_valid_i, unit_access_write_i,
  input wire logic [2:0]                      unit_access_sel_i, unit_clock_en_o,
  input wire logic                            unit_fault_o, unit_grant_o, irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic hit = |(unit_access_sel_i & unit_clock_en_o);
  a_fault_gated: assert property (unit_access_valid_i && !hit |-> unit_fault_o && !unit_grant_o)
    else $error("no fault on gated unit");
  a_grant_open: assert property (unit_access_valid_i && hit |-> unit_grant_o && !unit_fault_o)
    else $error("no grant on clocked unit");
  a_idle_quiet: assert property (!unit_access_valid_i |-> !unit_fault_o && !unit_grant_o)
    else $error("answer without access");
  a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside slot");
  a_reset_clear: assert property ($rose(reset_n_i) |-> unit_clock_en_o == 3'h0)
    else $error("enables set after reset");
  a_sleep_mask: assert property (reg_read_i && reg_addr_i == 12'h114
    |=> (reg_rdata_o & ~32'h0103_0000) == 32'h0000_0000) else $error("reserved bit set");
  a_write_back: assert property (reg_write_i && reg_addr_i == 12'h114 ##2 reg_read_i
    && reg_addr_i == 12'h114 |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 32'h0103_0000))
    else $error("sleep word lost");
  a_en_steady: assert property (!$past(reg_write_i) && $stable(power_state_i)
    |=> $stable(unit_clock_en_o)) else $error("enables moved alone");
endmodule : sleep_mode_clock_gating_properties
bind sleep_mode_clock_gating sleep_mode_clock_gating_properties u_props (.*);
`default_nettype wire

// ### test/sleep_mode_clock_gating_tb_top.sv
// self-checking bench for the sleep-mode clock gating block
// assumes package, design and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module sleep_mode_clock_gating_tb_top;
  logic                            clk_i, reset_n_i, wr, rd, av, aw, fault, grant, irq;
  logic [11:0]                     addr;
  logic [31:0]                     wd, rdata, rw, sw, dw;
  logic [2:0]                      sel, en;
  clock_gate_pkg::power_state_type st;
  int                              mismatches = 0, check_count = 0, cyc = 0;
  sleep_mode_clock_gating DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
    .power_state_i(st), .unit_access_valid_i(av), .unit_access_write_i(aw),
    .unit_access_sel_i(sel), .unit_fault_o(fault), .unit_grant_o(grant),
    .unit_clock_en_o(en), .irq_o(irq));
  // unit order: first counter, second counter, comparator
  function automatic logic [2:0] ue(input logic [31:0] w);
    return {w[24], w[17], w[16]};
  endfunction : ue
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 `CHK(n, e, rdata)
  endtask : rreg
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic chku(input int k);
    @(posedge clk_i);
    av <= 1'b1;
    aw <= 1'($urandom);
    sel <= 3'h1 << k;
    #1 `CHK("fault", ~en[k], fault)
    `CHK("grant", en[k], grant)
    @(posedge clk_i);
    av <= 1'b0;
  endtask : chku
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ceiling well above the few hundred cycles the tests take
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {reset_n_i, wr, rd, av, aw, addr, wd} = '0;
    sel = 3'h1;
    st = clock_gate_pkg::state_run;
    void'($urandom(32'h9ce6));
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rreg(12'h114, 32'h0000_0000, "sleep reset");
    `CHK("en reset", 3'h0, en)
    for (int i = 0; i < 6; i++) begin
      sw = (i == 0) ? 32'hffff_ffff : $urandom;
      wreg(12'h114, sw);
      rreg(12'h114, sw & 32'h0103_0000, "sleep word");
    end
    rreg(12'h300, 32'h0000_0000, "unmapped");
    $display("test readback done");
    for (int i = 0; i < 8; i++) begin
      rw = $urandom;
      sw = $urandom;
      dw = $urandom;
      wreg(12'h104, rw);
      wreg(12'h114, sw);
      wreg(12'h124, dw);
      wreg(12'h060, i[0] ? 32'h0800_0000 : 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
        st <= clock_gate_pkg::power_state_type'(k);
        settle();
        `CHK("enables", ue(!i[0] || k == 0 ? rw : k == 1 ? sw : dw), en)
        for (int u = 0; u < 3; u++) chku(u);
      end
    end
    $display("test selection done");
    wreg(12'h104, 32'h0000_0000);
    wreg(12'h060, 32'h0000_0000);
    wreg(12'h204, 32'h0000_0001);
    settle();
    wreg(12'h200, 32'h0000_0003);
    #1 `CHK("irq idle", 1'b0, irq)
    chku(0);
    settle();
    `CHK("irq raised", 1'b1, irq)
    rreg(12'h200, 32'h0000_0001, "status");
    wreg(12'h200, 32'h0000_0001);
    #1 `CHK("irq cleared", 1'b0, irq)
    wreg(12'h204, 32'h0000_0000);
    chku(0);
    settle();
    `CHK("irq masked", 1'b0, irq)
    // a run word that opens one unit must log an enable change and nothing else
    wreg(12'h200, 32'h0000_0003);
    wreg(12'h104, 32'h0001_0000);
    settle();
    `CHK("en on", 3'h1, en)
    rreg(12'h200, 32'h0000_0002, "change event");
    $display("test interrupt done");
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rreg(12'h114, 32'h0000_0000, "sleep rereset");
    `CHK("en rereset", 3'h0, en)
    rreg(12'h200, 32'h0000_0000, "status rereset");
    $display("test reset done");
    conclude();
  end
endmodule : sleep_mode_clock_gating_tb_top
`default_nettype wire
